// *** rtl/iar_ctrl.sv ***
// Angle readout, open-coil test, extrapolation and battery wake control
module iar_ctrl
    import iar_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // AXI4-Lite slave
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Front end sample stream
    input wire iar_sample_t frontSample,
    // Pins
    input wire logic [COIL_N-1:0] receiveCoilInputs,
    input wire logic mainBelowBattery,
    // Status outputs
    output logic coilTestActive,
    output logic batteryMode,
    output logic frontEndSleep,
    output iar_position_t positionOut
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [COIL_N:0] pinRaw;
    logic [COIL_N:0] pinStage1_reg;
    logic [COIL_N:0] pinStage2_reg;
    logic [COIL_N:0] pinStage3_reg;
    logic [COIL_N:0] pinFilt_reg;
    assign pinRaw = {mainBelowBattery, receiveCoilInputs};

    genvar gi;
    generate
        for (gi = 0; gi <= COIL_N; gi++) begin : gSync
            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    pinStage1_reg[gi] <= 1'b0;
                    pinStage2_reg[gi] <= 1'b0;
                    pinStage3_reg[gi] <= 1'b0;
                    pinFilt_reg[gi] <= 1'b0;
                end else begin
                    pinStage1_reg[gi] <= pinRaw[gi];
                    pinStage2_reg[gi] <= pinStage1_reg[gi];
                    pinStage3_reg[gi] <= pinStage2_reg[gi];
                    // A change counts only once two stages agree
                    if (pinStage2_reg[gi] == pinStage3_reg[gi]) begin
                        pinFilt_reg[gi] <= pinStage3_reg[gi];
                    end
                end
            end
        end
    endgenerate

    wire [COIL_N-1:0] coilOpenFilt = pinFilt_reg[COIL_N-1:0];
    wire supplyLow = pinFilt_reg[COIL_N];

    // ----------------------------------------
    // Register bus
    // ----------------------------------------
    logic awHeld_reg, wHeld_reg, bValid_reg, rValid_reg;
    logic [31:0] awAddr_reg, wData_reg, rData_reg;
    logic [3:0] wStrb_reg;
    logic [1:0] bResp_reg, rResp_reg;
    logic [15:0] control_reg, velGain_reg, accGain_reg, wakePeriod_reg;
    logic openCoil_reg, testBusy;

    wire awTake = s_axi_awvalid && s_axi_awready;
    wire wTake = s_axi_wvalid && s_axi_wready;
    wire arTake = s_axi_arvalid && s_axi_arready;
    wire doWrite = awHeld_reg && wHeld_reg && !bValid_reg;
    wire [7:0] wrIdx = awAddr_reg[9:2];
    wire [7:0] rdIdx = s_axi_araddr[9:2];
    wire wrHigh = (awAddr_reg[31:10] != 22'h000000);
    wire rdHigh = (s_axi_araddr[31:10] != 22'h000000);
    wire wrCtl = doWrite && !wrHigh && wrIdx == IDX_DIGITAL_CONTROL;
    wire wrVg = doWrite && !wrHigh && wrIdx == IDX_VELOCITY_GAIN;
    wire wrAg = doWrite && !wrHigh && wrIdx == IDX_ACCEL_GAIN;
    wire wrWp = doWrite && !wrHigh && wrIdx == IDX_WAKE_PERIOD;
    wire wrStatusRo = doWrite && !wrHigh && (wrIdx >= IDX_SENSOR_STATUS) && (wrIdx <= IDX_VELOCITY);
    wire wrMapped = wrCtl || wrVg || wrAg || wrWp || wrStatusRo;
    wire [15:0] byteMask = {{8{wStrb_reg[1]}}, {8{wStrb_reg[0]}}};

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] val,
                                            input logic [15:0] mask);
        merge16 = (old & ~mask) | (val & mask);
    endfunction

    // Trigger: a written one starts the test; ignored while one already runs
    // write starts test
    wire testStart = wrCtl && wStrb_reg[1] && wData_reg[CTL_TRIGGER_BIT] && !testBusy;

    assign s_axi_awready = !awHeld_reg && !bValid_reg;
    assign s_axi_wready = !wHeld_reg && !bValid_reg;
    assign s_axi_bvalid = bValid_reg;
    assign s_axi_bresp = bResp_reg;
    assign s_axi_arready = !rValid_reg;
    assign s_axi_rvalid = rValid_reg;
    assign s_axi_rdata = rData_reg;
    assign s_axi_rresp = rResp_reg;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            bValid_reg <= 1'b0;
            awAddr_reg <= 32'h00000000;
            wData_reg <= 32'h00000000;
            wStrb_reg <= 4'h0;
            bResp_reg <= RESP_OKAY;
        end else begin
            if (awTake) begin
                awHeld_reg <= 1'b1;
                awAddr_reg <= s_axi_awaddr;
            end
            if (wTake) begin
                wHeld_reg <= 1'b1;
                wData_reg <= s_axi_wdata;
                wStrb_reg <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld_reg <= 1'b0;
                wHeld_reg <= 1'b0;
                bValid_reg <= 1'b1;
                bResp_reg <= wrMapped ? RESP_OKAY : RESP_DECERR;
            end else if (bValid_reg && s_axi_bready) begin
                bValid_reg <= 1'b0;
            end
        end
    end

    // Trigger bit is never stored; it reflects the running test
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            control_reg <= CTL_RESET;
            velGain_reg <= GAIN_RESET;
            accGain_reg <= GAIN_RESET;
            wakePeriod_reg <= WAKE_PERIOD_RESET;
        end else begin
            if (wrCtl) begin
                control_reg <= merge16(control_reg, wData_reg[15:0], byteMask) & ~(16'h0001 << CTL_TRIGGER_BIT);
            end
            if (wrVg) begin
                velGain_reg <= merge16(velGain_reg, wData_reg[15:0], byteMask);
            end
            if (wrAg) begin
                accGain_reg <= merge16(accGain_reg, wData_reg[15:0], byteMask);
            end
            if (wrWp) begin
                wakePeriod_reg <= merge16(wakePeriod_reg, wData_reg[15:0], byteMask);
            end
        end
    end

    // ----------------------------------------
    // Read decode
    // ----------------------------------------
    logic [15:0] statusWord, controlView;
    logic [31:0] rdValue;
    logic rdMapped;
    assign controlView = control_reg | ({15'h0000, testBusy} << CTL_TRIGGER_BIT);
    assign statusWord = ({15'h0000, openCoil_reg} << STS_OPEN_COIL_BIT)
                      | ({15'h0000, testBusy} << STS_BUSY_BIT)
                      | ({15'h0000, batteryMode} << STS_BATTERY_BIT)
                      | ({15'h0000, frontEndSleep} << STS_ASLEEP_BIT);

    always_comb begin
        rdValue = 32'h00000000;
        rdMapped = !rdHigh;
        case (rdIdx)
            IDX_DIGITAL_CONTROL: rdValue = {16'h0000, controlView};
            IDX_SENSOR_STATUS: rdValue = {16'h0000, statusWord};
            IDX_ANGLE: rdValue = {12'h000, positionOut.angle};
            IDX_TURNS: rdValue = {{8{positionOut.turns[TURN_W-1]}}, positionOut.turns};
            IDX_VELOCITY: rdValue = {{12{positionOut.velocity[VEL_W-1]}}, positionOut.velocity};
            IDX_VELOCITY_GAIN: rdValue = {16'h0000, velGain_reg};
            IDX_ACCEL_GAIN: rdValue = {16'h0000, accGain_reg};
            IDX_WAKE_PERIOD: rdValue = {16'h0000, wakePeriod_reg};
            default: rdMapped = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rValid_reg <= 1'b0;
            rData_reg <= 32'h00000000;
            rResp_reg <= RESP_OKAY;
        end else if (arTake) begin
            rValid_reg <= 1'b1;
            rData_reg <= rdMapped ? rdValue : 32'h00000000;
            rResp_reg <= rdMapped ? RESP_OKAY : RESP_DECERR;
        end else if (rValid_reg && s_axi_rready) begin
            rValid_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // Open-coil test sequencer
    // ----------------------------------------
    typedef enum logic [1:0] {TST_STARTUP, TST_IDLE, TST_RUN} iar_test_state_t;
    iar_test_state_t testState_reg;
    logic [TIMER_W-1:0] testTimer_reg;
    assign testBusy = (testState_reg == TST_RUN);
    assign coilTestActive = testBusy;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            testState_reg <= TST_STARTUP;
            testTimer_reg <= '0;
            openCoil_reg <= 1'b0;
        end else begin
            case (testState_reg)
                TST_STARTUP: begin
                    // Waits so firmware can load the skip bit first
                    if (testStart || testTimer_reg == TIMER_W'(STARTUP_CYCLES - 1)) begin
                        testTimer_reg <= '0;
                        testState_reg <= (control_reg[CTL_SKIP_BIT] && !testStart) ? TST_IDLE : TST_RUN;
                    end else begin
                        testTimer_reg <= testTimer_reg + 1'b1;
                    end
                end
                TST_IDLE: begin
                    if (testStart) begin
                        testTimer_reg <= '0;
                        testState_reg <= TST_RUN;
                    end
                end
                TST_RUN: begin
                    if (testTimer_reg == TIMER_W'(COIL_TEST_CYCLES - 1)) begin
                        testTimer_reg <= '0;
                        openCoil_reg <= |coilOpenFilt;
                        testState_reg <= TST_IDLE;
                    end else begin
                        testTimer_reg <= testTimer_reg + 1'b1;
                    end
                end
                default: testState_reg <= TST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Battery wake sequencer
    // ----------------------------------------
    typedef enum logic [1:0] {BAT_MAIN, BAT_SLEEP, BAT_AWAKE} iar_bat_state_t;
    iar_bat_state_t batState_reg;
    logic [3:0] usDiv_reg;
    logic [TIMER_W-1:0] batTimer_reg;
    wire usTick = (usDiv_reg == 4'(US_TICK_CYCLES - 1));
    assign batteryMode = (batState_reg != BAT_MAIN);
    assign frontEndSleep = (batState_reg == BAT_SLEEP);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            usDiv_reg <= 4'h0;
        end else begin
            usDiv_reg <= usTick ? 4'h0 : usDiv_reg + 4'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            batState_reg <= BAT_MAIN;
            batTimer_reg <= '0;
        end else if (!supplyLow) begin
            batState_reg <= BAT_MAIN;
            batTimer_reg <= '0;
        end else begin
            case (batState_reg)
                BAT_MAIN: begin
                    batTimer_reg <= '0;
                    batState_reg <= BAT_SLEEP;
                end
                BAT_SLEEP: begin
                    if (usTick) begin
                        if (batTimer_reg >= wakePeriod_reg - 16'h0001) begin
                            batTimer_reg <= '0;
                            batState_reg <= BAT_AWAKE;
                        end else begin
                            batTimer_reg <= batTimer_reg + 1'b1;
                        end
                    end
                end
                BAT_AWAKE: begin
                    // Back to sleep after one sample or a bounded window
                    if (frontSample.valid || batTimer_reg == TIMER_W'(WAKE_WINDOW_CYCLES - 1)) begin
                        batTimer_reg <= '0;
                        batState_reg <= BAT_SLEEP;
                    end else begin
                        batTimer_reg <= batTimer_reg + 1'b1;
                    end
                end
                default: batState_reg <= BAT_MAIN;
            endcase
        end
    end

    // ----------------------------------------
    // Turn count, filters and extrapolation
    // ----------------------------------------
    logic [ANGLE_W-1:0] rawAngle_reg, angleLpf_reg;
    logic signed [VEL_W-1:0] rawVel_reg, velLpf_reg, accLpf_reg;
    logic signed [TURN_W-1:0] turns_reg;
    wire [2:0] lpfShift = control_reg[CTL_SHIFT_LSB +: 3];
    wire takeSample = frontSample.valid && !frontEndSleep;
    wire wrapUp = (rawAngle_reg[ANGLE_W-1 -: 2] == 2'b11) && (frontSample.angle[ANGLE_W-1 -: 2] == 2'b00);
    wire wrapDown = (rawAngle_reg[ANGLE_W-1 -: 2] == 2'b00) && (frontSample.angle[ANGLE_W-1 -: 2] == 2'b11);
    // Angle error wraps modulo one revolution
    wire signed [ANGLE_W-1:0] angErr = signed'(frontSample.angle - angleLpf_reg);
    wire signed [VEL_W:0] velErr = VEL_W'(0) + (21'(signed'(frontSample.velocity)) - 21'(velLpf_reg));
    wire signed [VEL_W:0] velStep = velErr >>> lpfShift;
    wire signed [VEL_W-1:0] velLpfNext = VEL_W'(21'(velLpf_reg) + velStep);
    wire signed [VEL_W:0] accRaw = 21'(velLpfNext) - 21'(velLpf_reg);
    wire signed [VEL_W:0] accStep = (accRaw - 21'(accLpf_reg)) >>> lpfShift;
    wire signed [35:0] velTerm = signed'(velGain_reg) * velLpf_reg;
    wire signed [35:0] accTerm = signed'(accGain_reg) * accLpf_reg;
    wire [ANGLE_W-1:0] extAngle = angleLpf_reg + velTerm[35:16] + accTerm[35:16];
    wire [ANGLE_W-1:0] reportAngle = control_reg[CTL_BYPASS_BIT] ? rawAngle_reg : extAngle;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rawAngle_reg <= '0;
            angleLpf_reg <= '0;
            rawVel_reg <= '0;
            velLpf_reg <= '0;
            accLpf_reg <= '0;
            turns_reg <= '0;
        end else if (takeSample) begin
            // angle kept as 20-bit fraction of a turn
            rawAngle_reg <= frontSample.angle;
            angleLpf_reg <= angleLpf_reg + ANGLE_W'(angErr >>> lpfShift);
            // velocity passes in its native scale
            rawVel_reg <= frontSample.velocity;
            velLpf_reg <= velLpfNext;
            accLpf_reg <= VEL_W'(21'(accLpf_reg) + accStep);
            if (wrapUp) begin
                turns_reg <= turns_reg + 24'sh000001;
            end else if (wrapDown) begin
                turns_reg <= turns_reg - 24'sh000001;
            end
        end
    end

    // velocity word keeps 2^29 per rev/us scale
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            positionOut <= '0;
        end else begin
            positionOut.angle <= reportAngle;
            positionOut.turns <= turns_reg;
            positionOut.velocity <= rawVel_reg;
        end
    end

endmodule

// *** rtl/iar_pkg.sv ***
// Shared constants and types for the inductive angle readout controller
package iar_pkg;

    // ----------------------------------------
    // Clock and timing
    // ----------------------------------------
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned STARTUP_DELAY_US = 100;
    localparam int unsigned COIL_TEST_US = 50;
    localparam int unsigned WAKE_WINDOW_US = 20;
    localparam int unsigned STARTUP_CYCLES = (STARTUP_DELAY_US * CLK_HZ + 999_999) / 1_000_000;
    localparam int unsigned COIL_TEST_CYCLES = (COIL_TEST_US * CLK_HZ + 999_999) / 1_000_000;
    localparam int unsigned WAKE_WINDOW_CYCLES = (WAKE_WINDOW_US * CLK_HZ + 999_999) / 1_000_000;
    localparam int unsigned US_TICK_CYCLES = CLK_HZ / 1_000_000;
    localparam int unsigned TIMER_W = 16;

    // ----------------------------------------
    // Register indices (byte address = 4 * index)
    // ----------------------------------------
    localparam logic [7:0] IDX_DIGITAL_CONTROL = 8'h03;
    localparam logic [7:0] IDX_SENSOR_STATUS = 8'h04;
    localparam logic [7:0] IDX_ANGLE = 8'h05;
    localparam logic [7:0] IDX_TURNS = 8'h06;
    localparam logic [7:0] IDX_VELOCITY = 8'h07;
    localparam logic [7:0] IDX_VELOCITY_GAIN = 8'h08;
    localparam logic [7:0] IDX_ACCEL_GAIN = 8'h09;
    localparam logic [7:0] IDX_WAKE_PERIOD = 8'h0A;

    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int unsigned CTL_BYPASS_BIT = 15;
    localparam int unsigned CTL_TRIGGER_BIT = 13;
    localparam int unsigned CTL_SKIP_BIT = 12;
    localparam int unsigned CTL_SHIFT_LSB = 0;
    localparam int unsigned STS_OPEN_COIL_BIT = 13;
    localparam int unsigned STS_BATTERY_BIT = 0;
    localparam int unsigned STS_BUSY_BIT = 1;
    localparam int unsigned STS_ASLEEP_BIT = 2;
    localparam logic [15:0] CTL_RESET = 16'h0000;
    localparam logic [15:0] GAIN_RESET = 16'h0000;
    localparam logic [15:0] WAKE_PERIOD_RESET = 16'h03E8;

    // ----------------------------------------
    // Data formats
    // ----------------------------------------
    localparam int unsigned ANGLE_W = 20;
    localparam int unsigned TURN_W = 24;
    localparam int unsigned VEL_W = 20;
    localparam int unsigned COIL_N = 8;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_DECERR = 2'b11;

    typedef struct packed {
        logic [ANGLE_W-1:0] angle;
        logic signed [TURN_W-1:0] turns;
        logic signed [VEL_W-1:0] velocity;
    } iar_position_t;

    typedef struct packed {
        logic valid;
        logic [ANGLE_W-1:0] angle;
        logic signed [VEL_W-1:0] velocity;
    } iar_sample_t;

endpackage

// *** tb/iar_ctrl_properties.sv ***
// Port-level checks for the readout controller
module iar_ctrl_properties
    import iar_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Register bus
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Supply, test and position
    input wire logic mainBelowBattery,
    input wire logic batteryMode,
    input wire logic frontEndSleep,
    input wire logic coilTestActive,
    input wire iar_position_t positionOut
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    // Length of the running test
    logic [15:0] testCnt_reg;
    always_ff @(posedge core_clk) begin
        testCnt_reg <= (sys_rst || !coilTestActive) ? 16'h0000 : testCnt_reg + 16'h0001;
    end
    ar_ready_a: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("arready wrong");
    read_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    battery_enter_a: assert property (mainBelowBattery [*8] |-> batteryMode)
        else $error("battery mode missed");
    battery_leave_a: assert property ((!mainBelowBattery) [*8] |-> !batteryMode)
        else $error("battery mode stuck");
    wake_window_a: assert property ($fell(frontEndSleep) && batteryMode |->
        ##[1:200] (frontEndSleep || !batteryMode)) else $error("wake window overrun");
    test_length_a: assert property ($fell(coilTestActive) |-> testCnt_reg == 16'(COIL_TEST_CYCLES))
        else $error("coil test length wrong");
    turn_step_a: assert property (!$stable(positionOut.turns) |->
        (positionOut.turns - $past(positionOut.turns)) inside {24'h000001, 24'hFFFFFF}) else $error("turn jump");
    test_c: cover property ($fell(coilTestActive));
    wake_c: cover property ($fell(frontEndSleep) && batteryMode);
    turn_c: cover property (!$stable(positionOut.turns));
endmodule

bind iar_ctrl iar_ctrl_properties chk_u (
    .core_clk, .sys_rst, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_bvalid, .s_axi_bready, .mainBelowBattery, .batteryMode, .frontEndSleep, .coilTestActive,
    .positionOut
);

// *** tb/iar_front_end_model.sv ***
// Behavioural sensor front end that feeds samples
module iar_front_end_model
    import iar_pkg::*;
(
    // Clock
    input wire logic core_clk,
    // Sleep request from the block
    input wire logic frontEndSleep,
    // Sample stream
    output iar_sample_t frontSample
);
    timeunit 1ns;
    timeprecision 1ns;
    initial frontSample = '0;
    task automatic send(input logic [19:0] a, v, input int slow);
        repeat (slow + 1) @(posedge core_clk);
        while (frontEndSleep !== 1'b0) @(posedge core_clk);
        frontSample <= '{1'b1, a, v};
        @(posedge core_clk);
        // Stale data would hide a capture on the wrong cycle
        frontSample <= '{1'b0, ~a, ~v};
    endtask
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the readout controller
module tb
    import iar_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] FULL = 32'hFFFFFFFF;
    logic core_clk = 1'b0, sys_rst = 1'b1, mainBelowBattery = 1'b0;
    logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
    logic [31:0] awAddr = '0, wData = '0, arAddr = '0, rData;
    logic [7:0] receiveCoilInputs = '0;
    logic awReady, wReady, bValid, arReady, rValid, coilTestActive, batteryMode, frontEndSleep;
    logic [1:0] bResp, rResp;
    iar_sample_t frontSample;
    iar_position_t positionOut;
    logic [19:0] lastAngle = '0;
    logic [23:0] expTurns = '0;
    int errorCnt = 0, cmpCount = 0, cycleCnt = 0;
    iar_ctrl dut_u (
        .core_clk, .sys_rst, .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
        .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady), .frontSample, .receiveCoilInputs, .mainBelowBattery,
        .coilTestActive, .batteryMode, .frontEndSleep, .positionOut
    );
    iar_front_end_model fe_u (.core_clk, .frontEndSleep, .frontSample);
    always #50 core_clk = ~core_clk;
    // ----
    // Bus tasks and expectations
    // ----
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [23:0] turnStep(input logic [19:0] p, n);
        if (p[19:18] == 2'h3 && n[19:18] == 2'h0) return 24'h000001;
        if (p[19:18] == 2'h0 && n[19:18] == 2'h3) return 24'hFFFFFF;
        return 24'h000000;
    endfunction
    // Gains fixed at a quarter and an eighth
    function automatic logic [19:0] extrap(input logic [19:0] a, v, pv);
        logic signed [39:0] p, q;
        p = $signed(v) * 16'sh4000;
        q = $signed(20'(v - pv)) * 16'sh2000;
        return a + p[35:16] + q[35:16];
    endfunction
    task automatic testDone();
        $display("comparisons %0d mismatches %0d", cmpCount, errorCnt);
        if (errorCnt == 0 && cmpCount > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] e, g);
        cmpCount++;
        if (g !== e) begin
            errorCnt++;
            $display("[FAIL] %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic axiWrite(input logic [31:0] a, d, output logic [1:0] r);
        awAddr <= a;
        wData <= d;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        do begin
            @(posedge core_clk);
            if (awReady) awValid <= 1'b0;
            if (wReady) wValid <= 1'b0;
        end while (bValid !== 1'b1);
        r = bResp;
        bReady <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic axiRead(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        do begin
            @(posedge core_clk);
            if (arReady) arValid <= 1'b0;
        end while (rValid !== 1'b1);
        d = rData;
        r = rResp;
        rReady <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic writeReg(input logic [31:0] a, d);
        logic [1:0] r;
        axiWrite(a, d, r);
        check("write resp", {30'h0, RESP_OKAY}, {30'h0, r});
    endtask
    task automatic expectReg(input string name, input logic [31:0] a, e, m);
        logic [31:0] d;
        logic [1:0] r;
        axiRead(a, d, r);
        check("read resp", {30'h0, RESP_OKAY}, {30'h0, r});
        check(name, e & m, d & m);
    endtask
    task automatic sample(input logic [19:0] a, v, input int slow);
        fe_u.send(a, v, slow);
        expTurns = expTurns + turnStep(lastAngle, a);
        lastAngle = a;
        repeat (3) @(posedge core_clk);
    endtask
    task automatic doReset();
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        lastAngle = '0;
        expTurns = '0;
        @(posedge core_clk);
    endtask
    always @(posedge core_clk) begin
        cycleCnt <= cycleCnt + 1;
        if (cycleCnt == 20000) begin
            errorCnt++;
            $display("[FAIL] run time expected 20000 seen more");
            testDone();
        end
    end
    // ----
    // Scenarios
    // ----
    initial begin
        logic [31:0] d, rnd;
        logic [19:0] a, v, pv;
        logic [1:0] r;
        int n;
        rnd = 32'hD706;
        doReset();
        expectReg("ctl reset", 32'h0C, 32'h0, FULL);
        expectReg("wake reset", 32'h28, 32'h3E8, FULL);
        writeReg(32'h10, 32'hFFFF);
        expectReg("status ro", 32'h10, 32'h0, FULL);
        axiWrite(32'h40, 32'h1, r);
        check("bad wr", {30'h0, RESP_DECERR}, {30'h0, r});
        axiRead(32'h40, d, r);
        check("bad rd", {30'h0, RESP_DECERR}, {30'h0, r});
        check("bad rd data", 32'h0, d);
        repeat (1200) if (coilTestActive !== 1'b1) @(posedge core_clk);
        check("startup test", 32'h1, {31'h0, coilTestActive});
        while (coilTestActive !== 1'b0) @(posedge core_clk);
        doReset();
        writeReg(32'h0C, 32'h1000);
        n = 0;
        repeat (1600) begin
            @(posedge core_clk);
            n += (coilTestActive !== 1'b0);
        end
        check("startup skip", 32'h0, n);
        for (int i = 0; i < 2; i++) begin
            rnd = lfsr(rnd);
            receiveCoilInputs <= i ? 8'h00 : (rnd[7:0] | 8'h01);
            writeReg(32'h0C, 32'h3000);
            check("test start", 32'h1, {31'h0, coilTestActive});
            expectReg("trigger busy", 32'h0C, 32'h2000, 32'h2000);
            expectReg("result held", 32'h10, {18'h0, i[0], 13'h0}, 32'h2000);
            while (coilTestActive !== 1'b0) @(posedge core_clk);
            expectReg("trigger done", 32'h0C, 32'h0, 32'h2000);
            repeat (2) expectReg("open coil", 32'h10, {18'h0, ~i[0], 13'h0}, 32'h2000);
        end
        writeReg(32'h20, 32'h4000);
        writeReg(32'h24, 32'h2000);
        for (int i = 0; i < 12; i++) begin
            rnd = lfsr(rnd);
            if (i % 6 == 0) writeReg(32'h0C, i ? 32'h1000 : 32'h9000);
            a = (i < 4) ? (i[0] ? 20'hF0000 : 20'h10000) : rnd[19:0];
            v = {rnd[31:14], 2'h0};
            sample(a, v, i % 3);
            check("turns out", {8'h0, expTurns}, {8'h0, positionOut.turns});
            expectReg("turns", 32'h18, {{8{expTurns[23]}}, expTurns}, FULL);
            expectReg("velocity", 32'h1C, {{12{v[19]}}, v}, FULL);
            expectReg("angle", 32'h14, {12'h0, (i < 6) ? a : extrap(a, v, pv)}, FULL);
            pv = v;
        end
        writeReg(32'h28, 32'h2);
        mainBelowBattery <= 1'b1;
        repeat (10) @(posedge core_clk);
        check("battery", 32'h1, {31'h0, batteryMode});
        expectReg("asleep", 32'h10, 32'h5, 32'h7);
        for (int i = 0; i < 2; i++) begin
            sample(i ? 20'h20000 : 20'hE0000, 20'h0, i);
            check("turns wake", {8'h0, expTurns}, {8'h0, positionOut.turns});
            repeat (4) @(posedge core_clk);
            check("asleep again", 32'h1, {31'h0, frontEndSleep});
        end
        mainBelowBattery <= 1'b0;
        repeat (10) @(posedge core_clk);
        check("main supply", 32'h0, {31'h0, batteryMode});
        testDone();
    end
endmodule
